// File: led_ctrl_regs.svh
// register offsets, reset values and timing counts of the led string controller
// assumes a 200 MHz ref_clk; included by every design file that needs a number
`ifndef LED_CTRL_REGS_SVH
`define LED_CTRL_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define REG_MAIN_REF 8'h20
`define REG_COLOR_REF 8'h21
`define REG_FAULT_MASK 8'h22
`define REG_FAULT_FLAGS 8'h23
`define REG_MAIN_DUTY 8'h24
`define REG_COLOR_DUTY 8'h25
`define REG_STATUS 8'h26

// ****************************************
// reset values and fields
// ****************************************
`define MAIN_REF_RST 8'h64
`define COLOR_REF_RST 8'h64
`define FAULT_MASK_RST 8'h00
`define DUTY_RST 8'h00
`define FLT_SHORT_BIT 0
`define FLT_OPEN_BIT 1
`define FLT_BITS 2
`define STAT_SLEEP_BIT 0
`define STAT_RUN_BIT 1
`define STAT_EN_BIT 2
`define SUPPLY_MIN 8'h00
`define SUPPLY_MAX 8'hff
// bus address of the device, arbitrary value
`define I2C_DEV_ADDR 7'h2a
`define I2C_LAST_BIT 3'h7
// eeprom holds one byte per register 0x20..0x25, word index = offset - 0x20
`define EE_WORDS 3'h6

// ****************************************
// timing
// ****************************************
`define CLK_HZ 200000000
`define DIM_HZ 400
`define DIM_STEPS 256
`define DIM_STEP_CYC (`CLK_HZ / (`DIM_HZ * `DIM_STEPS))
`define DIM_PHASE 8'h80
`define STARTUP_MS 250
`define STARTUP_CYC (`CLK_HZ / 1000 * `STARTUP_MS)
`define OPT_STEP_US 50
`define OPT_STEP_CYC (`CLK_HZ / 1000000 * `OPT_STEP_US)

`endif

// File: led_ctrl_pkg.sv
// state types of the led string controller
// assumes nothing of its surroundings
package led_ctrl_pkg;

  typedef enum logic [1:0] {SEQ_COPY, SEQ_WAIT, SEQ_OPT, SEQ_RUN} seq_e;

  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_PTR, I2C_PACK, I2C_WDAT, I2C_WACK, I2C_RDAT, I2C_RACK
  } i2c_e;

endpackage

// File: dim_if.sv
// signals between the sequencer and the dimming generator
// one clock domain, all members driven on ref_clk
`timescale 1ns/1ps

interface dim_if;
  logic run;
  logic input_mode;
  logic [7:0] main_duty;
  logic [7:0] color_duty;
  logic main_in;
  logic color_in;
  logic main_on;
  logic color_on;

  modport ctrl (output run, input_mode, main_duty, color_duty, main_in, color_in,
    input main_on, color_on);
  modport gen (input run, input_mode, main_duty, color_duty, main_in, color_in,
    output main_on, color_on);
endinterface

// File: dim_gen.sv
// dimming generator: fixed-rate register pwm or follow of the dimming inputs
// assumes main_in and color_in are already synchronised to ref_clk
`timescale 1ns/1ps
`include "led_ctrl_regs.svh"

module dim_gen (
  input wire logic ref_clk,
  input wire logic sys_rst,
  dim_if.gen d
);

  localparam logic [11:0] STEP_LAST = 12'(`DIM_STEP_CYC - 1);

  logic [11:0] step_reg;
  logic [7:0] phase_reg;
  logic main_on_reg;
  logic color_on_reg;

  // ****************************************
  // 256-step frame, rate rounds to 400.03 Hz
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !d.run) begin
      step_reg <= 12'h000;
      phase_reg <= 8'h00;
    end else if (step_reg == STEP_LAST) begin
      step_reg <= 12'h000;
      phase_reg <= phase_reg + 8'h01;
    end else begin
      step_reg <= step_reg + 12'h001;
    end
  end

  // color string runs half a frame behind the main string
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !d.run) begin
      main_on_reg <= 1'b0;
      color_on_reg <= 1'b0;
    end else if (d.input_mode) begin
      main_on_reg <= d.main_in;
      color_on_reg <= d.color_in;
    end else begin
      main_on_reg <= phase_reg < d.main_duty;
      color_on_reg <= 8'(phase_reg + `DIM_PHASE) < d.color_duty;
    end
  end

  assign d.main_on = main_on_reg;
  assign d.color_on = color_on_reg;

endmodule

// File: fault_latch.sv
// sticky fault flags of the color-adjust string
// assumes detector levels already synchronised; clear is a one-cycle pulse
`timescale 1ns/1ps
`include "led_ctrl_regs.svh"

module fault_latch (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic watch,
  input wire logic [`FLT_BITS-1:0] det,
  input wire logic [`FLT_BITS-1:0] mask,
  input wire logic clear,
  output logic [`FLT_BITS-1:0] flags,
  output logic active
);

  logic [`FLT_BITS-1:0] flag_reg;

  // a detection in the clear cycle wins, so a standing fault is never missed
  for (genvar i = 0; i < `FLT_BITS; i++) begin : g_flag
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        flag_reg[i] <= 1'b0;
      end else if (watch && det[i] && !mask[i]) begin
        flag_reg[i] <= 1'b1;
      end else if (clear) begin
        flag_reg[i] <= 1'b0;
      end
    end
  end

  assign flags = flag_reg;
  assign active = |flag_reg;

endmodule

// File: led_string_ctrl.sv
// control and protection logic of a two-string led driver
// assumes analog comparators for faults, temperature and headroom deliver levels
// on pins; eeprom answers one ref_clk cycle after its address; i2c host on scl/sda
`timescale 1ns/1ps
`include "led_ctrl_regs.svh"

module led_string_ctrl #(
  parameter int unsigned STARTUP_CYCLES = `STARTUP_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic enable_pin,
  input wire logic input_dim_variant,
  input wire logic main_dim_input,
  input wire logic color_dim_input,
  input wire logic color_short_det,
  input wire logic color_open_det,
  input wire logic temp_above_hot,
  input wire logic temp_below_cool,
  input wire logic headroom_low,
  input wire logic headroom_high,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic fault_out_n_out,
  output logic fault_out_n_oe_n,
  output logic [2:0] ee_addr,
  input wire logic [7:0] ee_data,
  output logic main_drive_en,
  output logic color_drive_en,
  output logic [7:0] supply_cmd,
  output logic [7:0] main_sense_reference,
  output logic [7:0] color_sense_reference
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign pin_raw = {enable_pin, input_dim_variant, main_dim_input, color_dim_input,
    color_short_det, color_open_det, temp_above_hot, temp_below_cool, scl_in, sda_in};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  logic en_s, variant_s, main_in_s, color_in_s, short_s, open_s, hot_s, cool_s, scl_s, sda_s;
  assign {en_s, variant_s, main_in_s, color_in_s, short_s, open_s, hot_s, cool_s, scl_s,
    sda_s} = sync2_reg;

  logic hr_low1_reg, hr_low_reg, hr_high1_reg, hr_high_reg;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hr_low1_reg <= 1'b0;
      hr_low_reg <= 1'b0;
      hr_high1_reg <= 1'b0;
      hr_high_reg <= 1'b0;
    end else begin
      hr_low1_reg <= headroom_low;
      hr_low_reg <= hr_low1_reg;
      hr_high1_reg <= headroom_high;
      hr_high_reg <= hr_high1_reg;
    end
  end

  // ****************************************
  // edge history
  // ****************************************
  logic en_d_reg, scl_d_reg, sda_d_reg;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      en_d_reg <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      en_d_reg <= en_s;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  logic en_rise, scl_rise, scl_fall, i2c_start, i2c_stop;
  assign en_rise = en_s && !en_d_reg;
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign i2c_start = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign i2c_stop = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // ****************************************
  // i2c slave, alive in every sequence state and in sleep
  // ****************************************
  led_ctrl_pkg::i2c_e i2c_reg;
  logic [7:0] sh_reg, tx_reg, ptr_reg;
  logic [2:0] cnt_reg;
  logic got_reg, rw_reg, nack_reg, wr_stb_reg, rd_stb_reg;
  logic [7:0] wr_addr_reg, wr_data_reg, rd_data;
  logic [`FLT_BITS-1:0] flags;
  logic [7:0] main_ref_reg, color_ref_reg, mask_reg, main_duty_reg, color_duty_reg;
  logic sleep_reg;
  led_ctrl_pkg::seq_e seq_reg;

  always_comb begin
    unique case (ptr_reg)
      `REG_MAIN_REF: rd_data = main_ref_reg;
      `REG_COLOR_REF: rd_data = color_ref_reg;
      `REG_FAULT_MASK: rd_data = mask_reg;
      `REG_FAULT_FLAGS: rd_data = {6'h00, flags};
      `REG_MAIN_DUTY: rd_data = main_duty_reg;
      `REG_COLOR_DUTY: rd_data = color_duty_reg;
      `REG_STATUS: rd_data = {5'h00, en_s, seq_reg == led_ctrl_pkg::SEQ_RUN, sleep_reg};
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    wr_stb_reg <= 1'b0;
    rd_stb_reg <= 1'b0;
    if (sys_rst || i2c_stop) begin
      i2c_reg <= led_ctrl_pkg::I2C_IDLE;
      sh_reg <= 8'h00;
      tx_reg <= 8'hff;
      cnt_reg <= 3'h0;
      got_reg <= 1'b0;
      nack_reg <= 1'b0;
      if (sys_rst) begin
        ptr_reg <= 8'h00;
        rw_reg <= 1'b0;
        wr_addr_reg <= 8'h00;
        wr_data_reg <= 8'h00;
      end
    end else if (i2c_start) begin
      i2c_reg <= led_ctrl_pkg::I2C_ADDR;
      cnt_reg <= 3'h0;
      got_reg <= 1'b0;
      tx_reg <= 8'hff;
    end else begin
      unique case (i2c_reg)
        led_ctrl_pkg::I2C_IDLE: begin
        end
        led_ctrl_pkg::I2C_ADDR, led_ctrl_pkg::I2C_PTR, led_ctrl_pkg::I2C_WDAT: begin
          if (scl_rise) begin
            sh_reg <= {sh_reg[6:0], sda_s};
            cnt_reg <= cnt_reg + 3'h1;
            got_reg <= cnt_reg == `I2C_LAST_BIT;
          end else if (scl_fall && got_reg) begin
            got_reg <= 1'b0;
            if (i2c_reg == led_ctrl_pkg::I2C_ADDR) begin
              rw_reg <= sh_reg[0];
              i2c_reg <= (sh_reg[7:1] == `I2C_DEV_ADDR) ? led_ctrl_pkg::I2C_AACK
                : led_ctrl_pkg::I2C_IDLE;
            end else if (i2c_reg == led_ctrl_pkg::I2C_PTR) begin
              ptr_reg <= sh_reg;
              i2c_reg <= led_ctrl_pkg::I2C_PACK;
            end else begin
              wr_stb_reg <= 1'b1;
              wr_addr_reg <= ptr_reg;
              wr_data_reg <= sh_reg;
              ptr_reg <= ptr_reg + 8'h01;
              i2c_reg <= led_ctrl_pkg::I2C_WACK;
            end
          end
        end
        led_ctrl_pkg::I2C_AACK, led_ctrl_pkg::I2C_PACK, led_ctrl_pkg::I2C_WACK: begin
          if (scl_fall) begin
            cnt_reg <= 3'h0;
            if (i2c_reg == led_ctrl_pkg::I2C_AACK && rw_reg) begin
              tx_reg <= rd_data;
              rd_stb_reg <= ptr_reg == `REG_FAULT_FLAGS;
              ptr_reg <= ptr_reg + 8'h01;
              i2c_reg <= led_ctrl_pkg::I2C_RDAT;
            end else begin
              i2c_reg <= (i2c_reg == led_ctrl_pkg::I2C_AACK) ? led_ctrl_pkg::I2C_PTR
                : led_ctrl_pkg::I2C_WDAT;
            end
          end
        end
        led_ctrl_pkg::I2C_RDAT: begin
          if (scl_fall) begin
            tx_reg <= {tx_reg[6:0], 1'b1};
            cnt_reg <= cnt_reg + 3'h1;
            if (cnt_reg == `I2C_LAST_BIT) begin
              i2c_reg <= led_ctrl_pkg::I2C_RACK;
            end
          end
        end
        led_ctrl_pkg::I2C_RACK: begin
          if (scl_rise) begin
            nack_reg <= sda_s;
          end else if (scl_fall) begin
            if (nack_reg) begin
              i2c_reg <= led_ctrl_pkg::I2C_IDLE;
            end else begin
              tx_reg <= rd_data;
              rd_stb_reg <= ptr_reg == `REG_FAULT_FLAGS;
              ptr_reg <= ptr_reg + 8'h01;
              cnt_reg <= 3'h0;
              i2c_reg <= led_ctrl_pkg::I2C_RDAT;
            end
          end
        end
      endcase
    end
  end

  // open-drain line: enable active low pulls sda to zero
  assign sda_out = 1'b0;
  assign sda_oe_n = !(i2c_reg == led_ctrl_pkg::I2C_AACK || i2c_reg == led_ctrl_pkg::I2C_PACK
    || i2c_reg == led_ctrl_pkg::I2C_WACK || (i2c_reg == led_ctrl_pkg::I2C_RDAT && !tx_reg[7]));

  // ****************************************
  // power-up sequence
  // ****************************************
  logic [25:0] wait_reg;
  logic [13:0] opt_reg;
  logic [2:0] ee_idx_reg;
  logic [7:0] supply_reg;
  logic opt_tick;
  assign opt_tick = opt_reg == 14'(`OPT_STEP_CYC - 1);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      seq_reg <= led_ctrl_pkg::SEQ_COPY;
      ee_idx_reg <= 3'h0;
      wait_reg <= '0;
    end else begin
      unique case (seq_reg)
        led_ctrl_pkg::SEQ_COPY: begin
          ee_idx_reg <= ee_idx_reg + 3'h1;
          if (ee_idx_reg == `EE_WORDS) begin
            seq_reg <= led_ctrl_pkg::SEQ_WAIT;
          end
        end
        led_ctrl_pkg::SEQ_WAIT: begin
          wait_reg <= wait_reg + 26'h1;
          if (wait_reg == 26'(STARTUP_CYCLES - 1)) begin
            seq_reg <= led_ctrl_pkg::SEQ_OPT;
          end
        end
        led_ctrl_pkg::SEQ_OPT: begin
          if (opt_tick && (!hr_low_reg || supply_reg == `SUPPLY_MAX)) begin
            seq_reg <= led_ctrl_pkg::SEQ_RUN;
          end
        end
        led_ctrl_pkg::SEQ_RUN: begin
        end
      endcase
    end
  end
  assign ee_addr = ee_idx_reg;

  // ****************************************
  // headroom optimizer, keeps tracking while running
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst || seq_reg == led_ctrl_pkg::SEQ_COPY || seq_reg == led_ctrl_pkg::SEQ_WAIT) begin
      opt_reg <= '0;
      supply_reg <= `SUPPLY_MIN;
    end else begin
      opt_reg <= opt_tick ? 14'h0000 : opt_reg + 14'h0001;
      if (opt_tick && hr_low_reg && supply_reg != `SUPPLY_MAX) begin
        supply_reg <= supply_reg + 8'h01;
      end else if (opt_tick && hr_high_reg && !hr_low_reg && supply_reg != `SUPPLY_MIN
          && seq_reg == led_ctrl_pkg::SEQ_RUN) begin
        supply_reg <= supply_reg - 8'h01;
      end
    end
  end
  assign supply_cmd = supply_reg;

  // ****************************************
  // control registers, eeprom image overrides any earlier value
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      main_ref_reg <= `MAIN_REF_RST;
      color_ref_reg <= `COLOR_REF_RST;
      mask_reg <= `FAULT_MASK_RST;
      main_duty_reg <= `DUTY_RST;
      color_duty_reg <= `DUTY_RST;
    end else if (seq_reg == led_ctrl_pkg::SEQ_COPY && ee_idx_reg != 3'h0) begin
      unique case (8'(`REG_MAIN_REF + {5'h00, ee_idx_reg} - 8'h01))
        `REG_MAIN_REF: main_ref_reg <= ee_data;
        `REG_COLOR_REF: color_ref_reg <= ee_data;
        `REG_FAULT_MASK: mask_reg <= ee_data;
        `REG_MAIN_DUTY: main_duty_reg <= ee_data;
        `REG_COLOR_DUTY: color_duty_reg <= ee_data;
        default: begin
        end
      endcase
    end else if (wr_stb_reg) begin
      unique case (wr_addr_reg)
        `REG_MAIN_REF: main_ref_reg <= wr_data_reg;
        `REG_COLOR_REF: color_ref_reg <= wr_data_reg;
        `REG_FAULT_MASK: mask_reg <= wr_data_reg;
        `REG_MAIN_DUTY: main_duty_reg <= wr_data_reg;
        `REG_COLOR_DUTY: color_duty_reg <= wr_data_reg;
        default: begin
        end
      endcase
    end
  end
  assign main_sense_reference = main_ref_reg;
  assign color_sense_reference = color_ref_reg;

  // ****************************************
  // thermal sleep with hysteresis
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sleep_reg <= 1'b0;
    end else if (hot_s) begin
      sleep_reg <= 1'b1;
    end else if (cool_s) begin
      sleep_reg <= 1'b0;
    end
  end

  // ****************************************
  // faults and dimming
  // ****************************************
  logic running, fault_active, fault_clear;
  logic [`FLT_BITS-1:0] fault_det;
  assign running = seq_reg == led_ctrl_pkg::SEQ_RUN && !sleep_reg && en_s;
  assign fault_det[`FLT_SHORT_BIT] = short_s;
  assign fault_det[`FLT_OPEN_BIT] = open_s;
  assign fault_clear = en_rise || rd_stb_reg
    || (wr_stb_reg && wr_addr_reg == `REG_FAULT_MASK);

  fault_latch u_fault (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .watch(running),
    .det(fault_det),
    .mask(mask_reg[`FLT_BITS-1:0]),
    .clear(fault_clear),
    .flags(flags),
    .active(fault_active)
  );

  dim_if dim ();
  assign dim.run = running;
  assign dim.input_mode = variant_s;
  assign dim.main_duty = main_duty_reg;
  assign dim.color_duty = color_duty_reg;
  assign dim.main_in = main_in_s;
  assign dim.color_in = color_in_s;

  dim_gen u_dim (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .d(dim.gen)
  );

  // sleep, startup wait and enable low all leave the strings undriven
  assign main_drive_en = running && dim.main_on;
  assign color_drive_en = running && dim.color_on && !fault_active;
  assign fault_out_n_out = 1'b0;
  assign fault_out_n_oe_n = !fault_active;

endmodule

// File: eeprom_model.sv
// stand-in for the control eeprom: one byte per register 0x20..0x25
// assumes the controller reads it only during its copy phase after reset
`timescale 1ns/1ps

module eeprom_model (
  input wire logic ref_clk,
  input wire logic [2:0] ee_addr,
  output logic [7:0] ee_data
);
  // stored main ref, color ref and main duty differ from reset values so a lost copy of those shows
  always_ff @(posedge ref_clk) begin
    case (ee_addr)
      3'h0: ee_data <= 8'h31;
      3'h1: ee_data <= 8'h32;
      3'h4: ee_data <= 8'h40;
      default: ee_data <= 8'h00;
    endcase
  end
endmodule

// File: led_string_ctrl_props.sv
// port-level assertions of the led string controller
// assumes one ref_clk domain and bind onto led_string_ctrl
`timescale 1ns/1ps

module led_string_ctrl_props #(
  parameter int unsigned STARTUP_CYCLES = 200
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic enable_pin,
  input wire logic temp_above_hot,
  input wire logic scl_in,
  input wire logic fault_out_n_oe_n,
  input wire logic main_drive_en,
  input wire logic color_drive_en,
  input wire logic [7:0] supply_cmd,
  input wire logic [7:0] main_sense_reference
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [31:0] up_cnt;
  logic [4:0] quiet_cnt;
  logic scl_q;
  // ****************************************
  // helper counters
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) up_cnt <= '0;
    else if (up_cnt != 32'hffffffff) up_cnt <= up_cnt + 32'h1;
  end
  always_ff @(posedge ref_clk) begin
    scl_q <= scl_in;
  end
  // a legal clear needs bus activity or enable low shortly before
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !enable_pin || scl_in != scl_q) quiet_cnt <= '0;
    else if (quiet_cnt != 5'h1f) quiet_cnt <= quiet_cnt + 5'h01;
  end
  // ****************************************
  // properties
  // ****************************************
  sequence hot_held; temp_above_hot [*6]; endsequence
  sequence en_low_held; !enable_pin [*6]; endsequence
  sequence step_seen; $changed(supply_cmd); endsequence
  chk_color_fault_off: assert property (!fault_out_n_oe_n |-> !color_drive_en)
    else $error("color string driven while fault latched");
  chk_sleep_dark: assert property (hot_held |-> !main_drive_en && !color_drive_en)
    else $error("strings driven while hot");
  chk_enable_dark: assert property (en_low_held |-> !main_drive_en && !color_drive_en)
    else $error("strings driven while disabled");
  chk_startup_dark: assert property (up_cnt < STARTUP_CYCLES |->
    !(main_drive_en || color_drive_en))
    else $error("strings driven during start-up wait");
  chk_supply_step: assert property (step_seen |->
    (supply_cmd == $past(supply_cmd) + 8'h01 && supply_cmd != 8'h00) ||
    (supply_cmd == $past(supply_cmd) - 8'h01 && supply_cmd != 8'hff))
    else $error("supply command jumped or wrapped");
  chk_supply_pace: assert property (step_seen |=> $stable(supply_cmd) [*8])
    else $error("supply command stepped too fast");
  chk_ref_default: assert property ($fell(sys_rst) |-> main_sense_reference == 8'h64)
    else $error("main reference not at default after reset");
  chk_fault_latched: assert property ($rose(fault_out_n_oe_n) |-> quiet_cnt < 5'h10)
    else $error("fault output released without a clear");
endmodule

bind led_string_ctrl led_string_ctrl_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .enable_pin(enable_pin),
  .temp_above_hot(temp_above_hot), .scl_in(scl_in), .fault_out_n_oe_n(fault_out_n_oe_n),
  .main_drive_en(main_drive_en), .color_drive_en(color_drive_en),
  .supply_cmd(supply_cmd), .main_sense_reference(main_sense_reference)
);

// File: led_string_ctrl_bench.sv
// self-checking bench of the led string controller
// assumes bit-banged i2c with a pull-up on sda and a short start-up count
`timescale 1ns/1ps
`include "led_ctrl_regs.svh"

module led_string_ctrl_bench;
  logic ref_clk, sys_rst, enable_pin, input_dim_variant, main_dim_input, color_dim_input;
  logic color_short_det, color_open_det, temp_above_hot, temp_below_cool;
  logic headroom_low, headroom_high, scl, sda_drv, sda_out, sda_oe_n;
  logic fault_out_n_out, fault_out_n_oe_n, main_drive_en, color_drive_en;
  logic [2:0] ee_addr;
  logic [7:0] ee_data, supply_cmd, main_sense_reference, color_sense_reference, v;
  wire sda_line = sda_drv & (sda_oe_n | sda_out);
  int error_cnt = 0;
  int checks_done = 0;

  led_string_ctrl #(.STARTUP_CYCLES(200)) u_led_string_ctrl (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .enable_pin(enable_pin),
    .input_dim_variant(input_dim_variant), .main_dim_input(main_dim_input),
    .color_dim_input(color_dim_input), .color_short_det(color_short_det),
    .color_open_det(color_open_det), .temp_above_hot(temp_above_hot),
    .temp_below_cool(temp_below_cool), .headroom_low(headroom_low),
    .headroom_high(headroom_high), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .fault_out_n_out(fault_out_n_out),
    .fault_out_n_oe_n(fault_out_n_oe_n), .ee_addr(ee_addr), .ee_data(ee_data),
    .main_drive_en(main_drive_en), .color_drive_en(color_drive_en),
    .supply_cmd(supply_cmd), .main_sense_reference(main_sense_reference),
    .color_sense_reference(color_sense_reference));
  eeprom_model u_eeprom_model (.ref_clk(ref_clk), .ee_addr(ee_addr), .ee_data(ee_data));

  // ****************************************
  // tasks
  // ****************************************
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // slow bit time keeps the two-cycle pin sync far from the edges
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    wt(10);
    scl = 1'b1;
    wt(20);
    r = sda_line;
    scl = 1'b0;
    wt(10);
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(1'b1, a);
  endtask
  task automatic start_c;
    sda_drv = 1'b1;
    wt(10);
    scl = 1'b1;
    wt(10);
    sda_drv = 1'b0;
    wt(10);
    scl = 1'b0;
  endtask
  task automatic stop_c;
    sda_drv = 1'b0;
    wt(10);
    scl = 1'b1;
    wt(10);
    sda_drv = 1'b1;
    wt(10);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic k0, k1, k2;
    start_c();
    xfer({`I2C_DEV_ADDR, 1'b0}, r, k0);
    xfer(a, r, k1);
    xfer(d, r, k2);
    stop_c();
    cmp({k0, k1, k2}, 8'h00);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] r;
    logic k0, k1, k2, k3;
    start_c();
    xfer({`I2C_DEV_ADDR, 1'b0}, r, k0);
    xfer(a, r, k1);
    start_c();
    xfer({`I2C_DEV_ADDR, 1'b1}, r, k2);
    xfer(8'hff, d, k3);
    stop_c();
    cmp({k0, k1, k2}, 8'h00);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    cmp(d, e);
  endtask
  task automatic do_reset;
    sys_rst = 1'b1;
    wt(16);
    cmp(main_sense_reference, 8'h64);
    sys_rst = 1'b0;
  endtask

  // ****************************************
  // clock, watchdog, tests
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    error_cnt++;
    final_report();
  end
  initial begin
    {sys_rst, enable_pin, input_dim_variant, main_dim_input, color_dim_input} = 5'h1f;
    {color_short_det, color_open_det, temp_above_hot, headroom_high} = 4'h0;
    {temp_below_cool, headroom_low, scl, sda_drv} = 4'hf;
    wt(1);
    do_reset();
    wt(300);
    cmp({main_drive_en, color_drive_en}, 8'h00);
    wt(22000);
    cmp(main_drive_en, 8'h00);
    cmp(supply_cmd != 8'h00, 8'h01);
    headroom_low = 1'b0;
    wt(10200);
    cmp({main_drive_en, color_drive_en}, 8'h03);
    chk_rd(`REG_MAIN_REF, 8'h31);
    chk_rd(`REG_COLOR_REF, 8'h32);
    wr(`REG_MAIN_REF, 8'h55);
    chk_rd(`REG_MAIN_REF, 8'h55);
    cmp(main_sense_reference, 8'h55);
    wr(`REG_COLOR_REF, 8'h77);
    cmp(color_sense_reference, 8'h77);
    chk_rd(8'h30, 8'h00);
    for (int i = 0; i < 4; i++) begin
      {color_dim_input, main_dim_input} = i[1:0];
      wt(400);
      cmp(main_drive_en, i[0]);
      cmp(color_drive_en, i[1]);
    end
    for (int k = 0; k < 2; k++) begin
      {color_open_det, color_short_det} = 2'b01 << k;
      wt(10);
      {color_open_det, color_short_det} = 2'b00;
      wt(50);
      cmp({fault_out_n_out, fault_out_n_oe_n, color_drive_en}, 8'h00);
      chk_rd(`REG_FAULT_FLAGS, 8'h01 << k);
      cmp(fault_out_n_oe_n, 8'h01);
      chk_rd(`REG_FAULT_FLAGS, 8'h00);
    end
    color_short_det = 1'b1;
    wt(10);
    chk_rd(`REG_FAULT_FLAGS, 8'h01);
    cmp(fault_out_n_oe_n, 8'h00);
    color_short_det = 1'b0;
    enable_pin = 1'b0;
    wt(20);
    enable_pin = 1'b1;
    wt(20);
    cmp({fault_out_n_oe_n, color_drive_en}, 8'h03);
    color_open_det = 1'b1;
    wt(10);
    color_open_det = 1'b0;
    wr(`REG_FAULT_MASK, 8'h01);
    cmp(fault_out_n_oe_n, 8'h01);
    color_short_det = 1'b1;
    wt(20);
    cmp(fault_out_n_oe_n, 8'h01);
    chk_rd(`REG_FAULT_FLAGS, 8'h00);
    color_short_det = 1'b0;
    wr(`REG_FAULT_MASK, 8'h00);
    {temp_below_cool, temp_above_hot} = 2'b01;
    wt(20);
    cmp({main_drive_en, color_drive_en}, 8'h00);
    rd(`REG_STATUS, v);
    cmp(v & 8'h01, 8'h01);
    temp_above_hot = 1'b0;
    wt(20);
    cmp(main_drive_en, 8'h00);
    temp_below_cool = 1'b1;
    wt(20);
    cmp({main_drive_en, color_drive_en}, 8'h03);
    input_dim_variant = 1'b0;
    wr(`REG_MAIN_DUTY, 8'h80);
    wr(`REG_COLOR_DUTY, 8'h80);
    for (int i = 0; i < 6; i++) begin
      wt(1500);
      cmp(main_drive_en ^ color_drive_en, 8'h01);
    end
    do_reset();
    wt(30);
    cmp(main_sense_reference, 8'h31);
    final_report();
  end
endmodule
